// [design/fbp_consts.vh]
`ifndef FBP_CONSTS_VH
`define FBP_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define FBP_IDX_DIR 16'hfebf
`define FBP_IDX_LATCH 16'hff6f
`define FBP_IDX_STATE 16'hff5f
`define FBP_IDX_SBYCTL 16'hff3a

// Address window decoded from haddr
`define FBP_ADDR_HI 17
`define FBP_ADDR_LO 2

// Field layout
`define FBP_PIN_MSB 4
`define FBP_HOLD_BIT 0
`define FBP_DIR_PIN4 4

// Reset and init values
`define FBP_DIR_RST 5'h00
`define FBP_DIR_MODE45 5'h10
`define FBP_LATCH_RST 5'h00
`define FBP_SBYCTL_RST 1'h0
`define FBP_UNDEF_READ 32'h00000000

// Operating modes
`define FBP_MODE_4 3'h4
`define FBP_MODE_5 3'h5
`define FBP_MODE_7 3'h7

// AHB encodings
`define FBP_HRESP_OKAY 1'h0

`endif

// [design/fbp_pin_cell.v]
`timescale 1ns/1ps
`include "fbp_consts.vh"

module fbp_pin_cell (
	input wire clk_in,
	input wire rstn_in,
	input wire bus_fn_in,
	input wire bus_val_in,
	input wire dir_in,
	input wire latch_in,
	input wire sw_standby_in,
	input wire hold_in,
	output reg pin_out,
	output reg pin_oe_out
);
	reg out_next;
	reg oe_next;

	always @* begin
		if (bus_fn_in) begin
			oe_next = ~(sw_standby_in & ~hold_in);
			out_next = sw_standby_in ? pin_out : bus_val_in;
		end else begin
			oe_next = dir_in;
			out_next = latch_in;
		end
	end

	// Idle level high so strobes stay inactive while released
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_out <= 1'b1;
			pin_oe_out <= 1'b0;
		end else begin
			pin_out <= out_next;
			pin_oe_out <= oe_next;
		end
	end
endmodule

// [design/fbp_port.v]
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "fbp_consts.vh"

// What this block does
// - The port has five pins, 4 down to 0, each usable as general input or output.
// - The direction register is write-only, reads give an undefined value, and bits 7 to 5 do nothing.
// - Power-on reset or hardware standby sets the pin 4 direction bit in modes 4 and 5, clears it in 6 and 7.
// - Manual reset and software standby leave the direction register unchanged.
// - In software standby the hold bit picks between keeping the bus strobe levels and floating them.
// - In mode 7 each pin is an output when its direction bit is 1 and an input when 0.
// - In modes 4 to 6 pins 4 to 1 drive chip selects 0 to 3 when their direction bit is 1, else are inputs.
// - In modes 4 to 6 pin 0 drives the column strobe when DRAM is selected, else follows its direction bit.
// - The output latch is read/write, bits 4 to 0 hold the pin data, bits 7 to 5 ignore writes.
// - Power-on reset or hardware standby clears the latch; manual reset and software standby keep it.
// - The pin-state register is read-only and ignores writes; software writes data to the latch.
// - A pin-state read gives the latch bit where the direction is 1 and the pin level where it is 0.
// - The pin-state register keeps its contents through manual reset and software standby.
// - The three port registers decode at their own fixed addresses.

module fbp_port #(
	parameter PINS = 5
) (
	input wire clk_in,
	input wire rstn_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output reg [31:0] hrdata_out,
	output wire hreadyout_out,
	output wire hresp_out,
	input wire [2:0] mode_in,
	input wire hw_standby_in,
	input wire manual_reset_in,
	input wire sw_standby_in,
	input wire dram_sel_in,
	input wire [3:0] chip_select_n_in,
	input wire cas_n_in,
	input wire [PINS-1:0] pin_in,
	output wire [PINS-1:0] pin_out,
	output wire [PINS-1:0] pin_oe_out
);
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_n;

	reg init_pending_reg;
	reg [PINS-1:0] dir_reg;
	reg [PINS-1:0] latch_reg;
	reg [PINS-1:0] pin_sample_reg;
	reg hold_reg;

	reg dphase_reg;
	reg dwrite_reg;
	reg [15:0] didx_reg;
	reg rd_wait_reg;

	wire addr_take;
	wire init_now;
	wire mode_ext;
	wire [PINS-1:0] state_view;
	wire [PINS-1:0] bus_fn;
	wire [PINS-1:0] bus_val;
	reg [31:0] rdata_next;

	function [15:0] reg_index;
		input [31:0] addr;
		begin
			reg_index = addr[`FBP_ADDR_HI:`FBP_ADDR_LO];
		end
	endfunction

	function is_write_to;
		input [15:0] idx;
		input [15:0] target;
		input wr;
		input ph;
		begin
			is_write_to = ph & wr & (idx == target);
		end
	endfunction

	// Reset released through two flops
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// Mode strap is only looked at after release, never under the async reset
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			init_pending_reg <= 1'b1;
		end else begin
			init_pending_reg <= 1'b0;
		end
	end
	assign init_now = init_pending_reg | hw_standby_in;
	assign mode_ext = (mode_in != `FBP_MODE_7);

	// AHB address phase capture; reads take one wait state so the data comes from a flop
	assign addr_take = hsel_in & htrans_in[1] & hready_in;

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dphase_reg <= 1'b0;
			dwrite_reg <= 1'b0;
			didx_reg <= 16'h0000;
		end else if (hready_in) begin
			dphase_reg <= addr_take;
			dwrite_reg <= hwrite_in;
			didx_reg <= reg_index(haddr_in);
		end
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_wait_reg <= 1'b0;
		end else begin
			rd_wait_reg <= addr_take & ~hwrite_in & ~rd_wait_reg;
		end
	end

	assign hreadyout_out = ~rd_wait_reg;
	assign hresp_out = `FBP_HRESP_OKAY;

	// Direction register
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg <= `FBP_DIR_RST;
		end else if (init_now) begin
			if (mode_in == `FBP_MODE_4 || mode_in == `FBP_MODE_5) begin
				dir_reg <= `FBP_DIR_MODE45;
			end else begin
				dir_reg <= `FBP_DIR_RST;
			end
		end else if (is_write_to(didx_reg, `FBP_IDX_DIR, dwrite_reg, dphase_reg)) begin
			dir_reg <= hwdata_in[PINS-1:0];
		end
	end

	// Output latch
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= `FBP_LATCH_RST;
		end else if (hw_standby_in) begin
			latch_reg <= `FBP_LATCH_RST;
		end else if (is_write_to(didx_reg, `FBP_IDX_LATCH, dwrite_reg, dphase_reg)) begin
			// Only bits 4 to 0 stored
			latch_reg <= hwdata_in[PINS-1:0];
		end
	end

	// Standby output hold control
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= `FBP_SBYCTL_RST;
		end else if (hw_standby_in) begin
			hold_reg <= `FBP_SBYCTL_RST;
		end else if (is_write_to(didx_reg, `FBP_IDX_SBYCTL, dwrite_reg, dphase_reg)) begin
			hold_reg <= hwdata_in[`FBP_HOLD_BIT];
		end
	end

	// Pin sampling; frozen so a read during software standby or manual reset shows the earlier view
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_sample_reg <= {PINS{1'b0}};
		end else if (!(sw_standby_in || manual_reset_in) || hw_standby_in) begin
			pin_sample_reg <= pin_in;
		end
	end

	assign state_view = (dir_reg & latch_reg) | (~dir_reg & pin_sample_reg);

	always @* begin
		rdata_next = `FBP_UNDEF_READ;
		case (didx_reg)
			`FBP_IDX_LATCH: rdata_next[PINS-1:0] = latch_reg;
			`FBP_IDX_STATE: rdata_next[PINS-1:0] = state_view;
			`FBP_IDX_SBYCTL: rdata_next[`FBP_HOLD_BIT] = hold_reg;
			`FBP_IDX_DIR: rdata_next = `FBP_UNDEF_READ;
			default: rdata_next = `FBP_UNDEF_READ;
		endcase
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_out <= 32'h00000000;
		end else if (rd_wait_reg) begin
			hrdata_out <= rdata_next;
		end
	end

	// Pin function select
	genvar i;
	generate
		for (i = 0; i < PINS; i = i + 1) begin : g_pin
			if (i == 0) begin : g_cas
				assign bus_fn[i] = mode_ext & dram_sel_in;
				assign bus_val[i] = cas_n_in;
			end else begin : g_cs
				// Chip selects on pins 4 to 1
				assign bus_fn[i] = mode_ext & dir_reg[i];
				assign bus_val[i] = chip_select_n_in[PINS-1-i];
			end
			fbp_pin_cell u_cell (
				.clk_in(clk_in),
				.rstn_in(rst_n),
				.bus_fn_in(bus_fn[i]),
				.bus_val_in(bus_val[i]),
				.dir_in(dir_reg[i]),
				.latch_in(latch_reg[i]),
				.sw_standby_in(sw_standby_in),
				.hold_in(hold_reg),
				.pin_out(pin_out[i]),
				.pin_oe_out(pin_oe_out[i])
			);
		end
	endgenerate
endmodule

// [testbench/fbp_pin_model.sv]
`timescale 1ns/1ps
module fbp_pin_model (
	input wire [4:0] drive_in,
	input wire [4:0] oe_in,
	input wire [4:0] ext_in,
	output wire [4:0] level_out
);
	// Undriven pins follow the outside level
	assign level_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule

// [testbench/fbp_port_chk.sv]
`timescale 1ns/1ps
`include "fbp_consts.vh"
module fbp_port_chk #(
	parameter PINS = 5
) (
	input wire clk_in,
	input wire rstn_in,
	input wire hsel_in,
	input wire [31:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire hready_in,
	input wire [31:0] hrdata_out,
	input wire hreadyout_out,
	input wire hresp_out,
	input wire [2:0] mode_in,
	input wire hw_standby_in,
	input wire sw_standby_in,
	input wire dram_sel_in,
	input wire [3:0] chip_select_n_in,
	input wire cas_n_in,
	input wire [PINS-1:0] pin_out,
	input wire [PINS-1:0] pin_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic [2:0] up_reg;
	// Internal reset lags the pin by two flops
	wire ok = up_reg == 3'h7;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			up_reg <= 3'h0;
		else if (!ok)
			up_reg <= up_reg + 3'h1;
	end
	sequence take_s(w);
		hsel_in && htrans_in[1] && hready_in && hwrite_in == w;
	endsequence
	sequence wait_s;
		!hreadyout_out ##1 hreadyout_out;
	endsequence
	a_resp_okay: assert property (hresp_out == `FBP_HRESP_OKAY) else $error("bad hresp");
	a_read_wait: assert property (take_s(1'b0) |=> wait_s) else $error("read wait");
	a_write_ready: assert property (take_s(1'b1) |=> hreadyout_out) else $error("write wait");
	a_dir_undef: assert property (take_s(1'b0) ##0 haddr_in[17:2] == `FBP_IDX_DIR
		|=> wait_s ##0 hrdata_out == `FBP_UNDEF_READ) else $error("dir read");
	a_upper_zero: assert property (hrdata_out[31:5] == 27'h0) else $error("upper bits");
	a_cs_follow: assert property (ok && $past(mode_in) != `FBP_MODE_7 && !$past(sw_standby_in)
		&& pin_oe_out[4] |-> pin_out[4] == $past(chip_select_n_in[0])) else $error("cs pin");
	a_cas_follow: assert property (ok && $past(mode_in) != `FBP_MODE_7 && $past(dram_sel_in)
		&& !$past(sw_standby_in) |-> pin_oe_out[0] && pin_out[0] == $past(cas_n_in)) else $error("cas pin");
	a_hw_init: assert property (ok && $past(hw_standby_in, 2) && !$past(sw_standby_in)
		&& !$past(dram_sel_in) && $past(mode_in) == $past(mode_in, 2) |-> pin_oe_out ==
		(($past(mode_in) == `FBP_MODE_4 || $past(mode_in) == `FBP_MODE_5) ? 5'h10 : 5'h00))
		else $error("hw init");
endmodule
bind fbp_port fbp_port_chk #(.PINS(PINS)) u_chk (.*);

// [testbench/five_bit_port_with_bus_strobes_bench.sv]
`timescale 1ns/1ps
`include "fbp_consts.vh"
module five_bit_port_with_bus_strobes_bench;
	logic clk_in, rstn_in, hs, hw, hsb, mr, ssb, ds, cas;
	logic [1:0] ht;
	logic [2:0] md;
	logic [3:0] cs;
	logic [4:0] ext;
	logic [31:0] ha, hd, q;
	wire ry, rp;
	wire [31:0] rd;
	wire [4:0] po, poe, pi;
	int mismatches, n_checks, cyc;
	fbp_port dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hs), .haddr_in(ha), .htrans_in(ht),
		.hwrite_in(hw), .hsize_in(3'h2), .hwdata_in(hd), .hready_in(ry), .hrdata_out(rd),
		.hreadyout_out(ry), .hresp_out(rp), .mode_in(md), .hw_standby_in(hsb), .manual_reset_in(mr),
		.sw_standby_in(ssb), .dram_sel_in(ds), .chip_select_n_in(cs), .cas_n_in(cas), .pin_in(pi),
		.pin_out(po), .pin_oe_out(poe));
	fbp_pin_model pm_u (.drive_in(po), .oe_in(poe), .ext_in(ext), .level_out(pi));
	initial begin
		clk_in = 0;
		forever #4 clk_in = ~clk_in;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task ck(input string nm, input [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	// Hready and read data are read right after the edge, so they show the pre-edge values
	task wt;
		do begin
			@(posedge clk_in);
		end while (ry !== 1'b1);
		q = rd;
	endtask
	task xf(input w, input [15:0] i, input [31:0] d);
		@(posedge clk_in);
		hs <= 1;
		ht <= 2'h2;
		hw <= w;
		ha <= {14'h0, i, 2'h0};
		wt;
		ht <= 2'h0;
		hs <= 0;
		hd <= d;
		wt;
	endtask
	task rc(input string nm, input [15:0] i, input [31:0] e);
		xf(1'b0, i, 32'h0);
		ck(nm, q, e);
	endtask
	// Ends on a rising edge: checks see the state after n edges, new inputs go on at that edge
	task st(input int n);
		repeat (n + 1) @(posedge clk_in);
	endtask
	task t_init;
		st(1);
		ck("oe m4", poe, 5'h10);
		rc("latch", `FBP_IDX_LATCH, 32'h0);
		rc("dir", `FBP_IDX_DIR, `FBP_UNDEF_READ);
		md <= `FBP_MODE_7;
		hsb <= 1;
		st(3);
		hsb <= 0;
		ck("oe m7", poe, 5'h00);
	endtask
	task t_port;
		xf(1, `FBP_IDX_LATCH, 32'hffffff15);
		rc("latch", `FBP_IDX_LATCH, 32'h15);
		xf(1, `FBP_IDX_DIR, 32'hffffff05);
		ext <= 5'h1a;
		st(2);
		ck("oe", poe, 5'h05);
		ck("out", po & poe, 5'h15 & 5'h05);
		rc("state", `FBP_IDX_STATE, (5'h15 & 5'h05) | (5'h1a & ~5'h05));
		xf(1, `FBP_IDX_STATE, 32'h0);
		rc("latch", `FBP_IDX_LATCH, 32'h15);
		rc("unmapped", 16'h0001, 32'h0);
	endtask
	task t_strobe;
		md <= `FBP_MODE_5;
		ds <= 1;
		cs <= 4'ha;
		cas <= 0;
		xf(1, `FBP_IDX_DIR, 32'h1e);
		st(2);
		ck("oe", poe, 5'h1f);
		ck("cs", po[4:1], {cs[0], cs[1], cs[2], cs[3]});
		ck("cas", po[0], cas);
		ds <= 0;
		xf(1, `FBP_IDX_DIR, 32'h1f);
		ssb <= 1;
		st(2);
		ck("float", poe, 5'h01);
		ck("port", po[0], 1'b1);
		ssb <= 0;
		xf(1, `FBP_IDX_SBYCTL, 32'h1);
		ssb <= 1;
		st(2);
		cs <= 4'h5;
		st(2);
		ck("hold oe", poe, 5'h1f);
		ck("hold cs", po[4:1], 4'h5);
		ssb <= 0;
	endtask
	task t_keep;
		md <= `FBP_MODE_7;
		xf(1, `FBP_IDX_DIR, 32'h03);
		xf(1, `FBP_IDX_LATCH, 32'h01);
		ext <= 5'h1c;
		st(2);
		mr <= 1;
		st(2);
		ext <= 5'h0b;
		st(2);
		ck("dir", poe, 5'h03);
		rc("state", `FBP_IDX_STATE, (5'h01 & 5'h03) | (5'h1c & ~5'h03));
		rc("latch", `FBP_IDX_LATCH, 32'h01);
		mr <= 0;
		hsb <= 1;
		st(2);
		hsb <= 0;
		rc("latch hw", `FBP_IDX_LATCH, 32'h0);
		rc("state hw", `FBP_IDX_STATE, 32'h0b);
	endtask
	initial begin
		{hs, hw, hsb, mr, ssb, ds, ht, ha, hd, ext} = 0;
		md = `FBP_MODE_4;
		cs = 4'hf;
		cas = 1;
		rstn_in = 0;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1;
		repeat (4) @(posedge clk_in);
		t_init;
		t_port;
		t_strobe;
		t_keep;
		finish_test;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			finish_test;
		end
	end
endmodule
